/* ssppl_line_drive.sv */
// Registered output drivers for each port line.
`timescale 1ns/1ns
module ssppl_line_drive #(
	parameter int N = 6
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_n,
	// Line controls and pad drive.
	ssppl_line_if.drv lines
);
	for (genvar i = 0; i < N; i++) begin : g_line
		logic next_enable;
		logic next_value;

		always_comb begin
			next_value  = lines.out_latch[i];
			next_enable = lines.direction_bits[i];
			if (i == ssppl_pkg::RX_LINE) begin
				next_enable = lines.direction_bits[i] && !lines.receiver_active;
			end else if (i == ssppl_pkg::TX_LINE) begin
				next_enable = lines.direction_bits[i] || lines.transmitter_active;
				if (lines.transmitter_active) begin
					next_value = lines.serial_tx_bit;
				end
			end
			// Open-drain lines let the external pullup supply a high level.
			if (lines.wired_or_select && next_value) begin
				next_enable = 1'b0;
			end
		end

		always_ff @(posedge clk) begin
			if (!rst_n) begin
				lines.pad_out[i]  <= 1'b0;
				lines.pad_oe_n[i] <= 1'b1;
			end else begin
				lines.pad_out[i]  <= next_value;
				lines.pad_oe_n[i] <= !next_enable;
			end
		end
	end
endmodule : ssppl_line_drive

/* ssppl_line_if.sv */
// Carrier between the register side and the pin drivers.
`timescale 1ns/1ns
interface ssppl_line_if #(
	parameter int N = 6
);
	logic [N-1:0] direction_bits;
	logic [N-1:0] out_latch;
	logic         wired_or_select;
	logic         receiver_active;
	logic         transmitter_active;
	logic         serial_tx_bit;
	logic [N-1:0] pad_out;
	logic [N-1:0] pad_oe_n;

	modport ctrl (
		output direction_bits,
		output out_latch,
		output wired_or_select,
		output receiver_active,
		output transmitter_active,
		output serial_tx_bit,
		input  pad_out,
		input  pad_oe_n
	);

	modport drv (
		input  direction_bits,
		input  out_latch,
		input  wired_or_select,
		input  receiver_active,
		input  transmitter_active,
		input  serial_tx_bit,
		output pad_out,
		output pad_oe_n
	);
endinterface : ssppl_line_if

/* ssppl_pin_sync.sv */
// Two-stage synchroniser for the port pin levels.
`timescale 1ns/1ns
module ssppl_pin_sync #(
	parameter int W = 6
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Levels.
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] stage_one;

	// The first stage feeds only the second, never any logic.
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				stage_one[i] <= 1'b0;
				sync_out[i]  <= 1'b0;
			end else begin
				stage_one[i] <= async_in[i];
				sync_out[i]  <= stage_one[i];
			end
		end
	end
endmodule : ssppl_pin_sync

/* ssppl_pin_world.sv */
// External circuitry on the port pins: pull-ups, outside drivers and pull-down faults.
`timescale 1ns/1ns
module ssppl_pin_world (
	// Pad drive from the port.
	input  wire logic [5:0] pad_out,
	input  wire logic [5:0] pad_oe_n,
	// Outside world.
	input  wire logic [5:0] ext_level,
	input  wire logic [5:0] ext_low,
	// Levels seen at the pins.
	output logic      [5:0] pad_in
);
	// An undriven line shows ext_level, which the bench sets per test as a pull-up or an outside driver.
	// An outside pull-down beats the port, as on a wired-OR line with a weak high side.
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pad_in[i] = ext_low[i] ? 1'b0 : (pad_oe_n[i] ? ext_level[i] : pad_out[i]);
		end
	end
endmodule : ssppl_pin_world

/* ssppl_pkg.sv */
// Constants shared by the shared serial port pin logic.
package ssppl_pkg;

	localparam int         LINE_COUNT           = 6;
	localparam int         RX_LINE              = 0;
	localparam int         TX_LINE              = 1;
	localparam int         ADDR_WIDTH           = 8;

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] DATA_OFFSET          = 8'h00;
	localparam logic [7:0] DIR_OFFSET           = 8'h04;
	localparam logic [7:0] CTRL_OFFSET          = 8'h08;
	localparam logic [7:0] STATUS_OFFSET        = 8'h0c;

	////////////////////////////////////////////////////////////////////////////////
	localparam int         CTRL_WIRED_OR_BIT    = 0;
	localparam int         CTRL_RX_ON_BIT       = 1;
	localparam int         CTRL_TX_ON_BIT       = 2;
	localparam int         STATUS_RX_ACTIVE_BIT = 0;
	localparam int         STATUS_TX_ACTIVE_BIT = 1;
	localparam int         STATUS_PIN_LSB       = 8;

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [5:0] DIR_RESET            = 6'h00;
	localparam logic [5:0] DATA_RESET           = 6'h00;
	localparam logic [2:0] CTRL_RESET           = 3'h0;

endpackage : ssppl_pkg

/* ssppl_port.sv */
// Six-line port with receive and transmit lines shared with the serial unit.
`timescale 1ns/1ns
module ssppl_port #(
	parameter int N = ssppl_pkg::LINE_COUNT
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Register bus.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	// Pins.
	input  wire logic [N-1:0] pad_in,
	output logic      [N-1:0] pad_out,
	output logic      [N-1:0] pad_oe_n,
	// Serial unit.
	input  wire logic        serial_tx_bit,
	input  wire logic        tx_shift_busy,
	output logic             rx_pin_level,
	output logic             receiver_active,
	output logic             transmitter_active
);
	logic [N-1:0] direction_bits;
	logic [N-1:0] out_latch;
	logic         wired_or_select;
	logic         rx_on_control;
	logic         tx_on_control;
	logic [N-1:0] pin_sync;
	logic         setup_phase;
	logic         bus_write;
	logic [31:0]  next_rdata;
	logic         next_err;

	ssppl_line_if #(.N(N)) lines ();

	////////////////////////////////////////////////////////////////////////////////
	// Pin sampling and drive.

	ssppl_pin_sync #(.W(N)) u_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (pad_in),
		.sync_out (pin_sync)
	);

	ssppl_line_drive #(.N(N)) u_drive (
		.clk   (clk),
		.rst_n (rst_n),
		.lines (lines.drv)
	);

	assign lines.direction_bits     = direction_bits;
	assign lines.out_latch          = out_latch;
	assign lines.wired_or_select    = wired_or_select;
	assign lines.receiver_active    = receiver_active;
	assign lines.transmitter_active = transmitter_active;
	assign lines.serial_tx_bit      = serial_tx_bit;
	assign pad_out                  = lines.pad_out;
	assign pad_oe_n                 = lines.pad_oe_n;

	// The receiver sees the pin whatever the direction bit says.
	assign rx_pin_level = pin_sync[ssppl_pkg::RX_LINE];

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	// Read data is captured at the setup edge, so the bus never needs a wait state.
	assign setup_phase = psel && !penable;
	assign bus_write   = psel && penable && pready && pwrite && !pslverr;

	always_comb begin
		next_rdata = 32'h00000000;
		next_err   = 1'b0;
		if (paddr == ssppl_pkg::DATA_OFFSET) begin
			// A line with its direction bit set reads its latch so a wired-OR low cannot corrupt it.
			next_rdata[N-1:0] = (direction_bits & out_latch)
				| (~direction_bits & pin_sync);
		end else if (paddr == ssppl_pkg::DIR_OFFSET) begin
			next_rdata[N-1:0] = direction_bits;
		end else if (paddr == ssppl_pkg::CTRL_OFFSET) begin
			next_rdata[ssppl_pkg::CTRL_WIRED_OR_BIT] = wired_or_select;
			next_rdata[ssppl_pkg::CTRL_RX_ON_BIT]    = rx_on_control;
			next_rdata[ssppl_pkg::CTRL_TX_ON_BIT]    = tx_on_control;
		end else if (paddr == ssppl_pkg::STATUS_OFFSET) begin
			next_rdata[ssppl_pkg::STATUS_RX_ACTIVE_BIT] = receiver_active;
			next_rdata[ssppl_pkg::STATUS_TX_ACTIVE_BIT] = transmitter_active;
			next_rdata[ssppl_pkg::STATUS_PIN_LSB +: N]  = pin_sync;
		end else begin
			next_err = 1'b1;
		end
	end

	// Every transfer completes in its first access cycle.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			pready  <= 1'b1;
			prdata  <= pwrite ? 32'h00000000 : next_rdata;
			pslverr <= next_err;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Port registers.

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			direction_bits <= ssppl_pkg::DIR_RESET;
		end else if (bus_write && paddr == ssppl_pkg::DIR_OFFSET) begin
			direction_bits <= pwdata[N-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_latch <= ssppl_pkg::DATA_RESET;
		end else if (bus_write && paddr == ssppl_pkg::DATA_OFFSET) begin
			out_latch <= pwdata[N-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wired_or_select <= ssppl_pkg::CTRL_RESET[ssppl_pkg::CTRL_WIRED_OR_BIT];
			rx_on_control   <= ssppl_pkg::CTRL_RESET[ssppl_pkg::CTRL_RX_ON_BIT];
			tx_on_control   <= ssppl_pkg::CTRL_RESET[ssppl_pkg::CTRL_TX_ON_BIT];
		end else if (bus_write && paddr == ssppl_pkg::CTRL_OFFSET) begin
			wired_or_select <= pwdata[ssppl_pkg::CTRL_WIRED_OR_BIT];
			rx_on_control   <= pwdata[ssppl_pkg::CTRL_RX_ON_BIT];
			tx_on_control   <= pwdata[ssppl_pkg::CTRL_TX_ON_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial takeover.

	// Clearing the transmit enable mid-character must not cut the character short.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			receiver_active    <= 1'b0;
			transmitter_active <= 1'b0;
		end else begin
			receiver_active    <= rx_on_control;
			transmitter_active <= tx_on_control || tx_shift_busy;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	dir_reset_a: assert property ($rose(rst_n)
		|-> direction_bits == ssppl_pkg::DIR_RESET && pad_oe_n == {N{1'b1}})
		else $error("Direction bits not cleared by reset.");

	dir_write_a: assert property (bus_write && paddr == ssppl_pkg::DIR_OFFSET
		|=> direction_bits == $past(pwdata[N-1:0]))
		else $error("Direction write not stored.");

	data_drive_a: assert property (bus_write && paddr == ssppl_pkg::DATA_OFFSET
		&& pwdata[2] && direction_bits[2] && !wired_or_select
		|=> ##1 !pad_oe_n[2] && pad_out[2])
		else $error("Written high level not driven on a plain output line.");

	read_source_a: assert property (setup_phase && !pwrite
		&& paddr == ssppl_pkg::DATA_OFFSET
		|=> prdata[N-1:0] == (($past(direction_bits) & $past(out_latch))
		| (~$past(direction_bits) & $past(pin_sync))))
		else $error("Port read took the wrong source.");

	open_drain_a: assert property (wired_or_select && out_latch[2] |=> pad_oe_n[2])
		else $error("Open-drain line drove a high level.");

	rx_off_a: assert property (receiver_active |=> pad_oe_n[ssppl_pkg::RX_LINE])
		else $error("Receive line driven while receiver active.");

	tx_drive_a: assert property (transmitter_active
		&& !(wired_or_select && serial_tx_bit)
		|=> !pad_oe_n[ssppl_pkg::TX_LINE]
		&& pad_out[ssppl_pkg::TX_LINE] == $past(serial_tx_bit))
		else $error("Transmit line not carrying the serial bit.");

	tx_hold_a: assert property (tx_shift_busy |=> transmitter_active)
		else $error("Transmitter released during a character.");

	tx_revert_a: assert property (!transmitter_active
		&& !direction_bits[ssppl_pkg::TX_LINE] |=> pad_oe_n[ssppl_pkg::TX_LINE])
		else $error("Idle transmit line with direction zero still driven.");

	////////////////////////////////////////////////////////////////////////////////
	// Bus protocol checks.

	pready_pulse_a: assert property (setup_phase |=> pready)
		else $error("No ready after a setup cycle.");

	pready_once_a: assert property (pready |=> !pready)
		else $error("Ready held longer than one access cycle.");

	err_pair_a: assert property (pslverr |-> pready)
		else $error("Error raised without ready.");

	bad_addr_a: assert property (setup_phase && paddr != ssppl_pkg::DATA_OFFSET
		&& paddr != ssppl_pkg::DIR_OFFSET && paddr != ssppl_pkg::CTRL_OFFSET
		&& paddr != ssppl_pkg::STATUS_OFFSET |=> pready && pslverr)
		else $error("Unmapped address not refused.");

	// An unmapped write must leave every register alone.
	err_no_write_a: assert property (pready && pslverr
		|=> $stable(direction_bits) && $stable(out_latch) && $stable(wired_or_select))
		else $error("Refused transfer changed a register.");

	data_write_a: assert property (bus_write && paddr == ssppl_pkg::DATA_OFFSET
		|=> out_latch == $past(pwdata[N-1:0]))
		else $error("Data write not latched.");

	ctrl_write_a: assert property (bus_write && paddr == ssppl_pkg::CTRL_OFFSET
		|=> wired_or_select == $past(pwdata[ssppl_pkg::CTRL_WIRED_OR_BIT]))
		else $error("Wired-OR select not stored.");

	write_zero_a: assert property (setup_phase && pwrite |=> prdata == 32'h00000000)
		else $error("Write returned nonzero read data.");

	dir_hold_a: assert property (!(bus_write && paddr == ssppl_pkg::DIR_OFFSET)
		|=> $stable(direction_bits))
		else $error("Direction bits changed without a write.");

	latch_hold_a: assert property (!(bus_write && paddr == ssppl_pkg::DATA_OFFSET)
		|=> $stable(out_latch))
		else $error("Output latch changed without a write.");

	////////////////////////////////////////////////////////////////////////////////
	// Serial and line checks.

	rx_on_a: assert property (rx_on_control |=> receiver_active)
		else $error("Receiver not switched on by its control.");

	rx_release_a: assert property (!rx_on_control |=> !receiver_active)
		else $error("Receiver still active after its control cleared.");

	tx_on_a: assert property (tx_on_control |=> transmitter_active)
		else $error("Transmit control did not take the line.");

	tx_idle_a: assert property (!tx_on_control && !tx_shift_busy
		|=> !transmitter_active)
		else $error("Transmitter kept the line with nothing to send.");

	tx_latch_a: assert property (!transmitter_active
		|=> pad_out[ssppl_pkg::TX_LINE] == $past(out_latch[ssppl_pkg::TX_LINE]))
		else $error("Idle transmit line not fed from the latch.");

	tx_port_drive_a: assert property (!transmitter_active
		&& direction_bits[ssppl_pkg::TX_LINE] && !wired_or_select
		|=> !pad_oe_n[ssppl_pkg::TX_LINE])
		else $error("Idle transmit line with direction one not driven.");

	input_line_a: assert property (!direction_bits[3] |=> pad_oe_n[3])
		else $error("Input line driven.");

	// The synchroniser clears in reset, so the pin check waits three clean edges.
	rx_pin_a: assert property ($past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3)
		|-> rx_pin_level == $past(pad_in[ssppl_pkg::RX_LINE], 2))
		else $error("Receive pin level not passed to the receiver.");

	////////////////////////////////////////////////////////////////////////////////
	// Coverage of the main scenarios.

	rx_on_c: cover property (rx_on_control ##1 receiver_active);
	tx_tail_c: cover property (!tx_on_control && tx_shift_busy ##1 transmitter_active);
	dir_read_c: cover property (setup_phase && !pwrite && paddr == ssppl_pkg::DIR_OFFSET);
	bad_addr_c: cover property (pready && pslverr);
	tx_done_c: cover property ($fell(transmitter_active));

endmodule : ssppl_port

/* ssppl_port_tb.sv */
// Self-checking bench for the shared serial port pin logic.
`timescale 1ns/1ns
module ssppl_port_tb;
	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [5:0]  pad_in;
	logic [5:0]  pad_out;
	logic [5:0]  pad_oe_n;
	logic        serial_tx_bit;
	logic        tx_shift_busy;
	logic        rx_pin_level;
	logic        receiver_active;
	logic        transmitter_active;
	logic [5:0]  ext_level;
	logic [5:0]  ext_low;
	logic [31:0] rd;
	logic        err;
	int          n_errors;
	int          tests_run;

	////////////////////////////////////////////////////////////////////////////////
	ssppl_port #(.N(6)) DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
		.serial_tx_bit(serial_tx_bit), .tx_shift_busy(tx_shift_busy),
		.rx_pin_level(rx_pin_level), .receiver_active(receiver_active),
		.transmitter_active(transmitter_active));
	ssppl_pin_world world (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_level(ext_level),
		.ext_low(ext_low), .pad_in(pad_in));

	initial clk = 1'b0;
	always #4 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Entered just after a rising edge; leaves one idle edge so no signal is set twice at once.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		chk("access cycles", 32'h1, 32'(n));
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask : rdchk

	// Pins need two sync edges and the pads one more, so four edges is enough.
	task automatic settle();
		repeat (4) @(posedge clk);
	endtask : settle

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		give_verdict();
	end

	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, serial_tx_bit, tx_shift_busy} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		ext_level = 6'h3f;
		ext_low = 6'h00;
		n_errors = 0;
		tests_run = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdchk(ssppl_pkg::DIR_OFFSET, 32'h0, "dir after reset");
		chk("oe_n after reset", 32'h3f, 32'(pad_oe_n));
		$display("test reset done");
		apb(1'b1, ssppl_pkg::DIR_OFFSET, 32'h2a);
		apb(1'b1, ssppl_pkg::DATA_OFFSET, 32'h3c);
		ext_level <= 6'h33;
		settle();
		rdchk(ssppl_pkg::DIR_OFFSET, 32'h2a, "dir");
		rdchk(ssppl_pkg::DATA_OFFSET, 32'h39, "data mixed");
		chk("oe_n mixed", 32'h15, 32'(pad_oe_n));
		chk("driven pads", 32'h28, 32'(pad_out & 6'h2a));
		$display("test direction done");
		apb(1'b1, ssppl_pkg::CTRL_OFFSET, 32'h1);
		apb(1'b1, ssppl_pkg::DIR_OFFSET, 32'h3f);
		ext_low <= 6'h3f;
		settle();
		chk("oe_n wired", 32'h3c, 32'(pad_oe_n));
		rdchk(ssppl_pkg::DATA_OFFSET, 32'h3c, "data pulled low");
		ext_low <= 6'h00;
		apb(1'b1, ssppl_pkg::CTRL_OFFSET, 32'h2);
		ext_level <= 6'h01;
		settle();
		chk("rx active", 32'h1, 32'(receiver_active));
		chk("rx oe_n", 32'h1, 32'(pad_oe_n[0]));
		chk("rx pin", 32'h1, 32'(rx_pin_level));
		rdchk(ssppl_pkg::DATA_OFFSET, 32'h3c, "rx latch read");
		rdchk(ssppl_pkg::CTRL_OFFSET, 32'h2, "ctrl rx on");
		rdchk(ssppl_pkg::STATUS_OFFSET, 32'h3d01, "status rx");
		apb(1'b1, ssppl_pkg::DIR_OFFSET, 32'h3e);
		settle();
		rdchk(ssppl_pkg::DATA_OFFSET, 32'h3d, "rx pin read");
		apb(1'b1, ssppl_pkg::CTRL_OFFSET, 32'h0);
		$display("test receiver done");
		apb(1'b1, ssppl_pkg::DIR_OFFSET, 32'h0);
		tx_shift_busy <= 1'b1;
		serial_tx_bit <= 1'b1;
		settle();
		chk("tx active", 32'h1, 32'(transmitter_active));
		chk("tx oe_n", 32'h0, 32'(pad_oe_n[1]));
		chk("tx bit one", 32'h1, 32'(pad_out[1]));
		rdchk(ssppl_pkg::DATA_OFFSET, 32'h3, "tx pin read");
		serial_tx_bit <= 1'b0;
		settle();
		chk("tx bit zero", 32'h0, 32'(pad_out[1]));
		tx_shift_busy <= 1'b0;
		apb(1'b1, ssppl_pkg::CTRL_OFFSET, 32'h4);
		settle();
		chk("tx enable oe_n", 32'h0, 32'(pad_oe_n[1]));
		tx_shift_busy <= 1'b1;
		apb(1'b1, ssppl_pkg::CTRL_OFFSET, 32'h0);
		settle();
		chk("tx held", 32'h1, 32'(transmitter_active));
		tx_shift_busy <= 1'b0;
		settle();
		chk("tx done oe_n", 32'h1, 32'(pad_oe_n[1]));
		apb(1'b1, ssppl_pkg::DIR_OFFSET, 32'h6);
		apb(1'b1, ssppl_pkg::DATA_OFFSET, 32'h6);
		settle();
		chk("tx port drive", 32'h2, {30'h0, pad_out[1], pad_oe_n[1]});
		chk("line two drive", 32'h2, {30'h0, pad_out[2], pad_oe_n[2]});
		$display("test transmitter done");
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped err", 32'h1, 32'(err));
		chk("unmapped data", 32'h0, rd);
		$display("test unmapped done");
		give_verdict();
	end
endmodule : ssppl_port_tb
